// [design/ebc_pkg.sv]
package ebc_pkg;

   // One core_clk period stands for half a CPU clock
   localparam int HALF_CLK = 1;
   localparam int FULL_CLK = 2 * HALF_CLK;

   localparam int NUM_WIN = 5;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int APB_AW = 8;
   localparam int MAX_WAIT_CODE = 15;

   // APB byte offsets
   localparam logic [7:0] SYS_ADDR = 8'h00;
   localparam logic [7:0] STAT_ADDR = 8'h04;
   localparam logic [7:0] CFG_BASE = 8'h10;
   localparam logic [7:0] RANGE_BASE = 8'h2C;

   // Segment line select codes
   localparam logic [1:0] SEG_1M = 2'h0;
   localparam logic [1:0] SEG_64K = 2'h1;
   localparam logic [1:0] SEG_4M = 2'h2;
   localparam logic [1:0] SEG_256K = 2'h3;

   typedef struct packed {
      logic stretch;
      logic mux;
      logic floatWait_n;
      logic cmdDelay_n;
      logic [3:0] waitCode;
   } cfg_t;

   typedef struct packed {
      logic enable;
      logic [5:0] base;
   } range_t;

   typedef struct packed {
      logic segOff;
      logic [1:0] segSel;
   } sys_t;

   typedef struct packed {
      cfg_t cfg;
      range_t range;
   } win_state_t;

   // Slowest cycle for the default window, slowest access without stretch or multiplexing for the others
   localparam cfg_t CFG0_RST = 8'hC0;
   localparam cfg_t CFGN_RST = 8'h00;
   localparam range_t RANGE_RST = 7'h00;
   localparam sys_t SYS_RST = 3'h0;

   typedef enum logic [2:0] {
      P_IDLE = 3'b000,
      P_STROBE = 3'b001,
      P_HOLD = 3'b010,
      P_DLY = 3'b011,
      P_CMD = 3'b100,
      P_FLOAT = 3'b101
   } phase_t;

   function automatic logic [5:0] accessHalves(input cfg_t c);
      logic [5:0] waits;
      waits = 6'(MAX_WAIT_CODE) - {2'h0, c.waitCode};
      accessHalves = 6'(FULL_CLK) * (waits + 6'h01);
   endfunction : accessHalves

   function automatic logic [2:0] floatHalves(input cfg_t c);
      floatHalves = 3'(FULL_CLK) * ({2'h0, ~c.floatWait_n} + {2'h0, c.mux});
   endfunction : floatHalves

   function automatic logic [ADDR_W-1:0] addrMask(input logic [1:0] sel);
      unique case (sel)
         SEG_1M: addrMask = 22'h0FFFFF;
         SEG_64K: addrMask = 22'h00FFFF;
         SEG_4M: addrMask = 22'h3FFFFF;
         SEG_256K: addrMask = 22'h03FFFF;
      endcase
   endfunction : addrMask

endpackage : ebc_pkg

// [design/window_cfg.sv]
`timescale 1ns/1ns
`default_nettype none
module window_cfg #(
   parameter ebc_pkg::cfg_t RESET_CFG = ebc_pkg::CFGN_RST,
   parameter bit HAS_RANGE = 1'b1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Register writes
   input wire logic cfgWrite,
   input wire logic rangeWrite,
   input wire logic [31:0] wdata,
   // Window match
   input wire logic [5:0] segAddr,
   output logic hit,
   output ebc_pkg::cfg_t cfg,
   output ebc_pkg::range_t range
);

   ebc_pkg::win_state_t st;
   ebc_pkg::win_state_t next_st;

   always_comb
   begin
      next_st = st;
      if (cfgWrite)
      begin
         next_st.cfg = wdata[7:0];
      end
      if (rangeWrite && HAS_RANGE)
      begin
         next_st.range = wdata[6:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= {RESET_CFG, ebc_pkg::RANGE_RST}; // [RULE_04] [RULE_07]
      end
      else
      begin
         st <= next_st;
      end
   end

   assign cfg = st.cfg;
   assign range = st.range;
   // The default window never matches; it catches what the others miss
   assign hit = HAS_RANGE && st.range.enable && st.range.base == segAddr;

endmodule : window_cfg
`default_nettype wire

// [design/ext_bus_cycle_timing.sv]
// Notes on behaviour
// [RULE_01] Segment lines select a 256 KByte, 1 MByte or 4 MByte address space.
// [RULE_02] Code segment pointer saved on interrupt entry unless segmentation is off.
// [RULE_03] Internal accesses complete at once, untouched by bus timing settings.
// [RULE_04] After reset external cycles use the slowest timing.
// [RULE_05] Stretch bit set lengthens the latch strobe by half a clock.
// [RULE_06] Stretched on multiplexed bus: extra half-clock address hold, data one clock later.
// [RULE_07] Default window stretch bit resets to one, others to zero.
// [RULE_08] Fifteen minus wait code extra clocks are inserted in the access.
// [RULE_09] CPU stalls during access waits when it needs that access.
// [RULE_10] Float wait bit zero adds one clock before the next address.
// [RULE_11] Recovery wait stalls only a following external access.
// [RULE_12] Multiplexed cycles add one more recovery clock.
// [RULE_13] Command starts with strobe fall, or half a clock later when delayed.
// [RULE_14] Delay applies when the command delay bit is zero, its reset value.
// [RULE_15] Command delay never lengthens the access.
// [RULE_16] Software should enable command delay on multiplexed windows.
// [RULE_17] Timing comes from the matched window, else the default window.
// [RULE_18] Cycle runs strobe, delay, access with waits, then recovery.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ext_bus_cycle_timing (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ebc_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU request and answer
   input wire logic reqValid,
   input wire logic reqInternal,
   input wire logic reqWrite,
   input wire logic reqNeedNow,
   input wire logic [ebc_pkg::ADDR_W-1:0] reqAddr,
   input wire logic [ebc_pkg::DATA_W-1:0] reqWdata,
   output logic reqReady,
   output logic reqDone,
   output logic [ebc_pkg::DATA_W-1:0] rdData,
   output logic cpuStall,
   // Interrupt entry
   input wire logic irqEntry,
   output logic segPtrSave,
   // External bus pins
   output logic latchStrobe,
   output logic rdCmd_b,
   output logic wrCmd_b,
   output logic [ebc_pkg::ADDR_W-1:0] extAddr,
   output logic [ebc_pkg::DATA_W-1:0] extDataOut,
   output logic extDataOe_b,
   input wire logic [ebc_pkg::DATA_W-1:0] extDataIn
);

   typedef struct packed {
      ebc_pkg::phase_t phase;
      logic [5:0] cnt;
      ebc_pkg::cfg_t cur;
      logic [2:0] winIdx;
      logic [ebc_pkg::ADDR_W-1:0] addr;
      logic write;
      logic needNow;
      logic [ebc_pkg::DATA_W-1:0] wdata;
      logic [ebc_pkg::DATA_W-1:0] rdata;
      logic done;
      logic segSave;
      ebc_pkg::sys_t sys;
      logic [ebc_pkg::DATA_W-1:0] sync1;
      logic [ebc_pkg::DATA_W-1:0] sync2;
      logic [ebc_pkg::DATA_W-1:0] sync3;
      logic [ebc_pkg::DATA_W-1:0] dataIn;
      logic strobe;
      logic rdCmd_b;
      logic wrCmd_b;
      logic [ebc_pkg::ADDR_W-1:0] pinAddr;
      logic [ebc_pkg::DATA_W-1:0] pinData;
      logic pinOe_b;
   } state_t;

   localparam state_t ST_RST = '{
      phase: ebc_pkg::P_IDLE,
      cur: ebc_pkg::CFG0_RST,
      sys: ebc_pkg::SYS_RST,
      rdCmd_b: 1'b1,
      wrCmd_b: 1'b1,
      pinOe_b: 1'b1,
      default: '0
   };

   state_t st;
   state_t next_st;

   ebc_pkg::cfg_t winCfg [ebc_pkg::NUM_WIN];
   ebc_pkg::range_t winRange [ebc_pkg::NUM_WIN];
   logic [ebc_pkg::NUM_WIN-1:0] winHit;
   logic apbWr;
   logic extReq;

   assign apbWr = psel && penable && pwrite;
   assign extReq = reqValid && !reqInternal;

   genvar gi;
   generate
      for (gi = 0; gi < ebc_pkg::NUM_WIN; gi++)
      begin : g_win
         window_cfg #(
            .RESET_CFG(gi == 0 ? ebc_pkg::CFG0_RST : ebc_pkg::CFGN_RST),
            .HAS_RANGE(gi != 0)
         ) u_win (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .cfgWrite(apbWr && paddr == ebc_pkg::CFG_BASE + 8'(4 * gi)),
            .rangeWrite(apbWr && paddr == ebc_pkg::RANGE_BASE + 8'(4 * gi)),
            .wdata(pwdata),
            .segAddr(reqAddr[21:16]),
            .hit(winHit[gi]),
            .cfg(winCfg[gi]),
            .range(winRange[gi])
         );
      end
   endgenerate

   // Lowest numbered matching window wins, else the default one
   ebc_pkg::cfg_t selCfg;
   logic [2:0] selIdx;
   always_comb
   begin
      selCfg = winCfg[0];
      selIdx = 3'h0;
      for (int i = ebc_pkg::NUM_WIN - 1; i > 0; i--)
      begin
         if (winHit[i])
         begin
            selCfg = winCfg[i]; // [RULE_17]
            selIdx = 3'(i);
         end
      end
   end

   // APB read side, zero wait states
   always_comb
   begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      if (paddr == ebc_pkg::SYS_ADDR)
      begin
         prdata = {29'h0, st.sys};
      end
      else if (paddr == ebc_pkg::STAT_ADDR)
      begin
         prdata = {26'h0, st.winIdx, st.phase};
      end
      // Holes between the last window and the range block must not index
      // past the window array
      else if (paddr >= ebc_pkg::CFG_BASE
               && paddr <= ebc_pkg::CFG_BASE + 8'(4 * (ebc_pkg::NUM_WIN - 1)))
      begin
         prdata = {24'h0, winCfg[3'((paddr - ebc_pkg::CFG_BASE) >> 2)]};
      end
      else if (paddr > ebc_pkg::RANGE_BASE
               && paddr <= ebc_pkg::RANGE_BASE + 8'(4 * (ebc_pkg::NUM_WIN - 1)))
      begin
         prdata = {25'h0, winRange[3'((paddr - ebc_pkg::RANGE_BASE) >> 2)]};
      end
      else
      begin
         pslverr = psel && penable;
      end
      if (paddr[1:0] != 2'h0)
      begin
         prdata = 32'h0000_0000;
         pslverr = psel && penable;
      end
   end
   assign pready = 1'b1;

   always_comb
   begin
      ebc_pkg::phase_t postPhase;
      logic [5:0] postCnt;
      logic [5:0] acc;
      postPhase = ebc_pkg::P_CMD;
      acc = ebc_pkg::accessHalves(st.cur); // [RULE_08]
      postCnt = acc - 6'h01;
      next_st = st;
      next_st.done = 1'b0;
      next_st.segSave = irqEntry && !st.sys.segOff; // [RULE_02]
      next_st.sync1 = extDataIn;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      if (st.sync2 == st.sync3)
      begin
         next_st.dataIn = st.sync3;
      end
      if (apbWr && paddr == ebc_pkg::SYS_ADDR)
      begin
         next_st.sys = pwdata[2:0];
      end
      // Command delay is taken out of the access, not added to it
      if (!st.cur.cmdDelay_n)
      begin
         postPhase = ebc_pkg::P_DLY; // [RULE_13] [RULE_14]
         postCnt = 6'h00;
      end
      unique case (st.phase)
         ebc_pkg::P_IDLE:
         begin
            if (reqValid && reqInternal)
            begin
               next_st.done = 1'b1; // [RULE_03]
            end
            else if (reqValid)
            begin
               next_st.phase = ebc_pkg::P_STROBE; // [RULE_18]
               next_st.cur = selCfg; // [RULE_17]
               next_st.winIdx = selIdx;
               // Plain strobe is one CPU clock, stretch adds half of one
               next_st.cnt = 6'(ebc_pkg::FULL_CLK - 1)
                             + {5'h00, selCfg.stretch}; // [RULE_05]
               next_st.addr = reqAddr & ebc_pkg::addrMask(st.sys.segSel); // [RULE_01]
               next_st.write = reqWrite;
               next_st.wdata = reqWdata;
               next_st.needNow = reqNeedNow;
            end
         end
         ebc_pkg::P_STROBE:
         begin
            if (st.cnt != 6'h00)
            begin
               next_st.cnt = st.cnt - 6'h01;
            end
            else if (st.cur.stretch && st.cur.mux)
            begin
               next_st.phase = ebc_pkg::P_HOLD; // [RULE_06]
               next_st.cnt = 6'h00;
            end
            else
            begin
               next_st.phase = postPhase;
               next_st.cnt = postCnt;
            end
         end
         ebc_pkg::P_HOLD:
         begin
            next_st.phase = postPhase;
            next_st.cnt = postCnt;
         end
         ebc_pkg::P_DLY:
         begin
            next_st.phase = ebc_pkg::P_CMD;
            next_st.cnt = acc - 6'h02; // [RULE_15]
         end
         ebc_pkg::P_CMD:
         begin
            if (st.cnt != 6'h00)
            begin
               next_st.cnt = st.cnt - 6'h01;
            end
            else
            begin
               next_st.done = 1'b1;
               if (!st.write)
               begin
                  next_st.rdata = st.dataIn;
               end
               if (ebc_pkg::floatHalves(st.cur) != 3'h0)
               begin
                  next_st.phase = ebc_pkg::P_FLOAT; // [RULE_10] [RULE_12]
                  next_st.cnt = {3'h0, ebc_pkg::floatHalves(st.cur) - 3'h1};
               end
               else
               begin
                  next_st.phase = ebc_pkg::P_IDLE;
               end
            end
         end
         ebc_pkg::P_FLOAT:
         begin
            if (st.cnt != 6'h00)
            begin
               next_st.cnt = st.cnt - 6'h01;
            end
            else
            begin
               next_st.phase = ebc_pkg::P_IDLE;
            end
         end
         default:
         begin
            next_st.phase = ebc_pkg::P_IDLE;
         end
      endcase
      // Pins are registered from the next phase to keep them glitch free
      next_st.strobe = next_st.phase == ebc_pkg::P_STROBE;
      next_st.rdCmd_b = !(next_st.phase == ebc_pkg::P_CMD && !next_st.write);
      next_st.wrCmd_b = !(next_st.phase == ebc_pkg::P_CMD && next_st.write);
      next_st.pinAddr = next_st.addr;
      if (next_st.cur.mux && (next_st.phase == ebc_pkg::P_STROBE
                              || next_st.phase == ebc_pkg::P_HOLD))
      begin
         next_st.pinData = next_st.addr[15:0];
         next_st.pinOe_b = 1'b0; // [RULE_06]
      end
      else
      begin
         next_st.pinData = next_st.wdata;
         next_st.pinOe_b = !(next_st.write
                             && (next_st.phase == ebc_pkg::P_DLY
                                 || next_st.phase == ebc_pkg::P_CMD));
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st <= ST_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   // A new request is only taken when no cycle or recovery is running
   assign reqReady = st.phase == ebc_pkg::P_IDLE;
   assign cpuStall = (st.phase != ebc_pkg::P_IDLE
                      && st.phase != ebc_pkg::P_FLOAT && st.needNow) // [RULE_09]
                     || (st.phase == ebc_pkg::P_FLOAT && extReq
                         && reqNeedNow); // [RULE_11]
   assign reqDone = st.done;
   assign rdData = st.rdata;
   assign segPtrSave = st.segSave;
   assign latchStrobe = st.strobe;
   assign rdCmd_b = st.rdCmd_b;
   assign wrCmd_b = st.wrCmd_b;
   assign extAddr = st.pinAddr;
   assign extDataOut = st.pinData;
   assign extDataOe_b = st.pinOe_b;

   // Helper counters for the checks below
   logic [5:0] cmdRun;
   logic [2:0] floatRun;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmdRun <= 6'h00;
         floatRun <= 3'h0;
      end
      else
      begin
         cmdRun <= (st.phase == ebc_pkg::P_DLY || st.phase == ebc_pkg::P_CMD)
                   ? cmdRun + 6'h01 : 6'h00;
         floatRun <= st.phase == ebc_pkg::P_FLOAT ? floatRun + 3'h1 : 3'h0;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   property p_strobe_plain;
      $rose(latchStrobe) && !st.cur.stretch |-> latchStrobe ##1 latchStrobe
         ##1 !latchStrobe;
   endproperty
   a_strobe_plain: assert property (p_strobe_plain) // [RULE_05]
      else $error("Plain strobe is not one CPU clock");

   property p_strobe_stretch;
      $rose(latchStrobe) && st.cur.stretch |-> latchStrobe[*3] ##1 !latchStrobe;
   endproperty
   a_strobe_stretch: assert property (p_strobe_stretch) // [RULE_05]
      else $error("Stretched strobe is not one and a half CPU clocks");

   property p_mux_hold;
      $fell(latchStrobe) && st.cur.stretch && st.cur.mux |-> !extDataOe_b
         && rdCmd_b && wrCmd_b && extDataOut == st.addr[15:0];
   endproperty
   a_mux_hold: assert property (p_mux_hold) // [RULE_06]
      else $error("Address not held after stretched strobe");

   property p_cmd_delay;
      $fell(latchStrobe) && !st.cur.stretch && !st.cur.cmdDelay_n
         |-> (rdCmd_b && wrCmd_b) ##1 !(rdCmd_b && wrCmd_b);
   endproperty
   a_cmd_delay: assert property (p_cmd_delay) // [RULE_13]
      else $error("Delayed command not half a clock after strobe");

   property p_cmd_nodelay;
      $fell(latchStrobe) && !st.cur.stretch && st.cur.cmdDelay_n
         |-> !(rdCmd_b && wrCmd_b);
   endproperty
   a_cmd_nodelay: assert property (p_cmd_nodelay) // [RULE_13]
      else $error("Undelayed command not with strobe fall");

   property p_access_len;
      st.phase == ebc_pkg::P_CMD && st.cnt == 6'h00
         |-> cmdRun + 6'h01 == ebc_pkg::accessHalves(st.cur);
   endproperty
   a_access_len: assert property (p_access_len) // [RULE_08] [RULE_15]
      else $error("Access length does not match wait code");

   property p_float_len;
      st.phase == ebc_pkg::P_FLOAT && st.cnt == 6'h00
         |-> floatRun + 3'h1 == ebc_pkg::floatHalves(st.cur);
   endproperty
   a_float_len: assert property (p_float_len) // [RULE_10] [RULE_12]
      else $error("Recovery length does not match settings");

   property p_internal;
      reqValid && reqReady && reqInternal |=> reqDone && !latchStrobe
         && st.phase == ebc_pkg::P_IDLE;
   endproperty
   a_internal: assert property (p_internal) // [RULE_03]
      else $error("Internal access did not finish at once");

   property p_float_nostall;
      st.phase == ebc_pkg::P_FLOAT && !(extReq && reqNeedNow) |-> !cpuStall;
   endproperty
   a_float_nostall: assert property (p_float_nostall) // [RULE_11]
      else $error("CPU stalled during recovery");

   property p_seg_save;
      irqEntry |=> segPtrSave == !$past(st.sys.segOff);
   endproperty
   a_seg_save: assert property (p_seg_save) // [RULE_02]
      else $error("Segment pointer save wrong");

endmodule : ext_bus_cycle_timing
`default_nettype wire

// [tb/ext_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
   // Clock
   input wire logic core_clk,
   // Bus pins from the block
   input wire logic latchStrobe,
   input wire logic rdCmd_b,
   input wire logic wrCmd_b,
   input wire logic [21:0] extAddr,
   input wire logic [15:0] extDataOut,
   input wire logic extDataOe_b,
   // Data back to the block
   output logic [15:0] extDataIn
);
   logic [15:0] mem [16];
   logic [3:0] idx;
   logic [15:0] last;
   // Address taken only under the strobe, as an external latch would
   always_ff @(posedge core_clk)
   begin
      if (latchStrobe)
         idx <= extAddr[3:0];
      if (!wrCmd_b && !extDataOe_b)
         mem[idx] <= extDataOut;
      if (!rdCmd_b)
         last <= mem[idx];
   end
   // Released bus shows the inverse, so stale data cannot pass
   assign extDataIn = !rdCmd_b ? mem[idx] : ~last;
endmodule : ext_mem_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic core_clk = 1'h0;
   logic rst_b = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err;
   logic reqValid = 1'h0, reqInternal = 1'h0, reqWrite = 1'h0;
   logic reqNeedNow = 1'h0, irqEntry = 1'h0;
   logic [21:0] reqAddr = 22'h0, extAddr, seenAddr;
   logic [15:0] reqWdata = 16'h0, rdData, extDataOut, extDataIn;
   logic reqReady, reqDone, cpuStall, segPtrSave;
   logic latchStrobe, rdCmd_b, wrCmd_b, extDataOe_b;
   int bad_count = 0, checked = 0, cycles = 0;
   int sCnt, cmdCnt, fCnt, stallCnt, doneIdx, gap, intDone;
   logic [7:0] tbl [5] = '{8'h3F, 8'h2F, 8'h89, 8'hEC, 8'h40};
   logic [1:0] segCode [4];
   logic [21:0] segMask [4] = '{22'h0FFFFF, 22'h03FFFF, 22'h3FFFFF,
                                22'h00FFFF};

   always #50 core_clk = ~core_clk;

   ext_bus_cycle_timing u_ext_bus_cycle_timing (
      .core_clk(core_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reqValid(reqValid),
      .reqInternal(reqInternal), .reqWrite(reqWrite),
      .reqNeedNow(reqNeedNow), .reqAddr(reqAddr),
      .reqWdata(reqWdata), .reqReady(reqReady), .reqDone(reqDone),
      .rdData(rdData), .cpuStall(cpuStall), .irqEntry(irqEntry),
      .segPtrSave(segPtrSave), .latchStrobe(latchStrobe),
      .rdCmd_b(rdCmd_b), .wrCmd_b(wrCmd_b), .extAddr(extAddr),
      .extDataOut(extDataOut), .extDataOe_b(extDataOe_b),
      .extDataIn(extDataIn));

   ext_mem_model u_ext_mem_model (
      .core_clk(core_clk), .latchStrobe(latchStrobe),
      .rdCmd_b(rdCmd_b), .wrCmd_b(wrCmd_b), .extAddr(extAddr),
      .extDataOut(extDataOut), .extDataOe_b(extDataOe_b),
      .extDataIn(extDataIn));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      // Ends once pready is high; the hang guard ends it if pready never rises
      do
      begin
         @(posedge core_clk);
      end
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic setCfg(input int w, input logic [7:0] v);
      apb(ebc_pkg::CFG_BASE + 8'(4 * w), 1'h1, {24'h0, v});
   endtask : setCfg

   // Measures one CPU access cycle by cycle after it is taken
   task automatic run(input logic [21:0] a, input logic w,
                      input logic [15:0] d, input logic intl,
                      input logic nn);
      int i;
      int sLast;
      int cFirst;
      @(posedge core_clk);
      reqAddr <= a;
      reqWrite <= w;
      reqWdata <= d;
      reqInternal <= intl;
      reqNeedNow <= nn;
      reqValid <= 1'h1;
      i = 0;
      do
      begin
         @(posedge core_clk);
         i++;
      end
      while (reqReady !== 1'h1);
      reqValid <= 1'h0;
      sCnt = 0;
      cmdCnt = 0;
      fCnt = 0;
      stallCnt = 0;
      doneIdx = -1;
      sLast = -1;
      cFirst = -1;
      for (i = 0; i < 90; i++)
      begin
         @(negedge core_clk);
         if (latchStrobe === 1'h1)
         begin
            if (sCnt == 0)
               seenAddr = extAddr;
            sCnt++;
            sLast = i;
         end
         if ((rdCmd_b & wrCmd_b) !== 1'h1)
         begin
            cmdCnt++;
            if (cFirst < 0)
               cFirst = i;
         end
         if (cpuStall === 1'h1)
            stallCnt++;
         if (reqDone === 1'h1)
            doneIdx = i;
         if (doneIdx >= 0 && reqReady !== 1'h1)
            fCnt++;
         if (doneIdx >= 0 && reqReady === 1'h1)
            break;
      end
      gap = cFirst - sLast - 1;
   endtask : run

   task automatic chkCycle(input logic [7:0] c, input logic nn);
      int s, h, a, f, dl;
      s = 2 + c[7];
      h = c[7] & c[6];
      a = 2 * (16 - int'(c[3:0]));
      dl = c[4] ? 0 : 1;
      f = 2 * (c[5] ? 0 : 1) + 2 * c[6];
      chk("length", doneIdx - intDone, s + h + a);
      chk("strobe", sCnt, s);
      chk("cmdGap", gap, h + dl);
      chk("cmdLen", cmdCnt, a - dl);
      chk("float", fCnt, f);
      chk("stall", stallCnt, nn ? s + h + a : 0);
   endtask : chkCycle

   // Hang guard, far above the several hundred cycles the tests take
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         stop_test();
      end
   end

   initial
   begin
      segCode = '{ebc_pkg::SEG_1M, ebc_pkg::SEG_256K, ebc_pkg::SEG_4M,
                  ebc_pkg::SEG_64K};
      repeat (4) @(posedge core_clk);
      rst_b <= 1'h1;
      apb(ebc_pkg::SYS_ADDR, 1'h0, 32'h0);
      chk("sys", rd, 32'h0);
      apb(ebc_pkg::CFG_BASE, 1'h0, 32'h0);
      chk("cfg0", rd, 32'hC0);
      for (int w = 1; w < 5; w++)
      begin
         apb(ebc_pkg::CFG_BASE + 8'(4 * w), 1'h0, 32'h0);
         chk("cfgN", rd, 32'h0);
      end
      apb(8'h08, 1'h0, 32'h0);
      chk("unmapped", {31'h0, err}, 32'h1);
      $display("test reset values done");
      run(22'h000100, 1'h0, 16'h0, 1'h1, 1'h1);
      intDone = doneIdx;
      chk("intStrobe", sCnt, 0);
      run(22'h000003, 1'h1, 16'hA5C3, 1'h0, 1'h1);
      chkCycle(8'hC0, 1'h1);
      run(22'h000003, 1'h0, 16'h0, 1'h0, 1'h0);
      chkCycle(8'hC0, 1'h0);
      chk("rdData", rdData, 16'hA5C3);
      $display("test slowest cycle done");
      // Multiplexed entries all keep the command delay on
      for (int k = 0; k < 5; k++)
      begin
         setCfg(0, tbl[k]);
         run(22'(k), 1'h1, 16'h1230 + 16'(k), 1'h0, 1'h0);
         chkCycle(tbl[k], 1'h0);
         run(22'(k), 1'h0, 16'h0, 1'h0, 1'h1);
         chkCycle(tbl[k], 1'h1);
         // Short commands end before the input synchroniser settles
         if (tbl[k][3:0] <= 4'hC)
            chk("rdData", rdData, 16'h1230 + 16'(k));
      end
      $display("test timing table done");
      setCfg(0, 8'h20);
      for (int w = 1; w < 5; w++)
      begin
         setCfg(w, {4'h3, 4'(15 - w)});
         apb(ebc_pkg::RANGE_BASE + 8'(4 * w), 1'h1, 32'h40 + 32'(16 + w));
         run({6'(16 + w), 16'h0008}, 1'h0, 16'h0, 1'h0, 1'h0);
         chkCycle({4'h3, 4'(15 - w)}, 1'h0);
      end
      apb(ebc_pkg::RANGE_BASE + 8'hC, 1'h1, 32'h52);
      run(22'h120008, 1'h0, 16'h0, 1'h0, 1'h0);
      chkCycle(8'h3D, 1'h0);
      apb(ebc_pkg::STAT_ADDR, 1'h0, 32'h0);
      chk("status", rd, 32'h10);
      run(22'h3F0008, 1'h0, 16'h0, 1'h0, 1'h0);
      chkCycle(8'h20, 1'h0);
      $display("test windows done");
      for (int k = 0; k < 4; k++)
      begin
         apb(ebc_pkg::SYS_ADDR, 1'h1, {30'h0, segCode[k]});
         run(22'h3FFFF5, 1'h0, 16'h0, 1'h0, 1'h0);
         chk("segAddr", seenAddr, 22'h3FFFF5 & segMask[k]);
      end
      for (int k = 0; k < 2; k++)
      begin
         apb(ebc_pkg::SYS_ADDR, 1'h1, {29'h0, 1'(k), 2'h0});
         @(posedge core_clk);
         irqEntry <= 1'h1;
         @(posedge core_clk);
         irqEntry <= 1'h0;
         @(negedge core_clk);
         chk("segSave", segPtrSave, k == 0);
      end
      $display("test segments done");
      stop_test();
   end
endmodule : testbench
`default_nettype wire
